// ===== hdl/bwpc_pkg.sv
// Purpose: Shared constants and types for the host bus width port configuration.
// Assumes: One 50 MHz clock, asynchronous active-high reset.
// Notes: Both ends, the checker and the testbench use these names.
package bwpc_pkg;
  typedef enum logic [1:0] {
    BWPC_W8 = 2'h0,
    BWPC_W16 = 2'h1,
    BWPC_W32 = 2'h3
  } bwpc_width_t;

  typedef enum logic [1:0] {
    BWPC_IDLE = 2'h0,
    BWPC_ACK = 2'h1,
    BWPC_NEGATE = 2'h3,
    BWPC_RELEASE = 2'h2
  } bwpc_dev_state_t;

  typedef enum logic [1:0] {
    BWPC_H_IDLE = 2'h0,
    BWPC_H_WAIT = 2'h1,
    BWPC_H_END = 2'h3
  } bwpc_host_state_t;

  localparam int unsigned BWPC_DATA_W = 32;
  localparam int unsigned BWPC_LANE_W = 8;
  localparam logic [31:0] BWPC_DATA_RESET = 32'h00000000;
  // Extra wait cycles before acknowledge; zero means no extra wait states.
  localparam logic [3:0] BWPC_WAIT_CYCLES = 4'h2;
  // Host gives up after this many cycles without an acknowledge.
  localparam logic [7:0] BWPC_HOST_TIMEOUT = 8'hFF;

  // Strap pair (size, bit0) to a width code
  function automatic logic [1:0] bwpc_decode_straps(input logic size_strap,
                                                    input logic a0_strap);
    if (!size_strap) begin
      bwpc_decode_straps = BWPC_W8;
    end else if (!a0_strap) begin
      bwpc_decode_straps = BWPC_W16;
    end else begin
      bwpc_decode_straps = BWPC_W32;
    end
  endfunction : bwpc_decode_straps

  // Replicates the low lanes so that every lane the host reads is valid
  function automatic logic [31:0] bwpc_join_lanes(input logic [1:0] width,
                                                  input logic [31:0] data);
    if (width == BWPC_W8) begin
      bwpc_join_lanes = {4{data[7:0]}};
    end else if (width == BWPC_W16) begin
      bwpc_join_lanes = {2{data[15:0]}};
    end else begin
      bwpc_join_lanes = data;
    end
  endfunction : bwpc_join_lanes
endpackage : bwpc_pkg

// ===== hdl/bwpc_if.sv
// Purpose: Bus between host and coprocessor port, with resolved acknowledge pins.
// Assumes: Acknowledges are pulled high when nobody drives them.
// Notes: The pull-up holding resistor is modelled by the resolution below.
`timescale 1ns/1ps
`default_nettype none
interface bwpc_if;
  logic address_strobe_n;
  logic data_strobe_n;
  logic chip_select_n;
  logic read_not_write;
  logic addr_bit4;
  logic [31:0] host_data;
  logic [31:0] dev_data;
  logic dev_data_oe;
  logic ack_low_order_out;
  logic ack_low_order_oe;
  logic ack_high_order_out;
  logic ack_high_order_oe;
  logic ack_low_order;
  logic ack_high_order;

  assign ack_low_order = ack_low_order_oe ? ack_low_order_out : 1'b1;
  assign ack_high_order = ack_high_order_oe ? ack_high_order_out : 1'b1;

  modport device (
    input address_strobe_n, data_strobe_n, chip_select_n, read_not_write, addr_bit4,
    input host_data,
    output dev_data, dev_data_oe,
    output ack_low_order_out, ack_low_order_oe, ack_high_order_out, ack_high_order_oe
  );
  modport host (
    output address_strobe_n, data_strobe_n, chip_select_n, read_not_write, addr_bit4,
    output host_data,
    input dev_data, dev_data_oe, ack_low_order, ack_high_order
  );
endinterface : bwpc_if
`default_nettype wire

// ===== hdl/bwpc_device.sv
// Purpose: Coprocessor end of the host port: width straps and acknowledge timing.
// Assumes: Straps are static; bus inputs arrive from another domain.
// Notes: Data storage is one word standing in for the coprocessor registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Both straps high selects 32-bit bus.
// - Width high, bit0 low selects 16-bit.
// - Width strap low selects 8-bit bus.
// - 16-bit: low acknowledge never asserted.
// - 8-bit: high acknowledge never asserted.
// - Host joins D0-D15 to D16-D31 in 16-bit.
// - Host joins D0-D7 to every lane in 8-bit.
// - Plain peripheral decoded in data space.
// - Alternate-space host decodes like coprocessor.
// - 8-bit peripheral uses low acknowledge only.
// - 32-bit: bit4 one both, else high only.
// - Both acknowledges negated means wait states.
// - After strobe rise, drive negated then release.
module bwpc_device (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic addr_bit0_strap,
  input wire logic size_strap,
  bwpc_if.device bus,
  output logic [1:0] bus_width,
  output logic [31:0] last_write_data,
  output logic write_seen
);
  typedef struct packed {
    logic [2:0] as_sync;
    logic [2:0] ds_sync;
    logic [1:0] cs_sync;
    logic [1:0] rw_sync;
    logic [1:0] a4_sync;
    logic straps_taken;
    logic [1:0] width;
    bwpc_pkg::bwpc_dev_state_t state;
    logic [3:0] wait_cnt;
    logic ack_lo;
    logic ack_hi;
    logic ack_oe;
    logic [31:0] store;
    logic [31:0] dout;
    logic dout_oe;
    logic wr_seen;
  } bwpc_dev_t;

  // Idle pins other than bit4 read high, so no false strobe edge follows reset
  localparam bwpc_dev_t BWPC_DEV_RESET = '{
    as_sync: 3'h7,
    ds_sync: 3'h7,
    cs_sync: 2'h3,
    rw_sync: 2'h3,
    a4_sync: 2'h0,
    straps_taken: 1'b0,
    width: bwpc_pkg::BWPC_W8,
    state: bwpc_pkg::BWPC_IDLE,
    wait_cnt: 4'h0,
    ack_lo: 1'b1,
    ack_hi: 1'b1,
    ack_oe: 1'b0,
    store: bwpc_pkg::BWPC_DATA_RESET,
    dout: bwpc_pkg::BWPC_DATA_RESET,
    dout_oe: 1'b0,
    wr_seen: 1'b0
  };

  // One step of a two-stage pin synchroniser
  function automatic logic [1:0] sync2(
    input logic [1:0] cur,
    input logic pin
  );
    sync2 = {cur[0], pin};
  endfunction : sync2

  // Three stages: the third only feeds the edge detector
  function automatic logic [2:0] sync3(
    input logic [2:0] cur,
    input logic pin
  );
    sync3 = {cur[1:0], pin};
  endfunction : sync3

  // Rising strobe between the second and third stages
  function automatic logic rose(input logic [2:0] hist);
    rose = hist[1] && !hist[2];
  endfunction : rose

  // Acknowledge pair {high, low}, active low
  function automatic logic [1:0] ack_pair(
    input logic [1:0] width,
    input logic a4
  );
    logic [1:0] pair;
    pair = 2'h3;
    unique case (width)
      bwpc_pkg::BWPC_W32: begin
        pair = {1'b0, !a4};
      end
      bwpc_pkg::BWPC_W16: begin
        pair = 2'h1;
      end
      default: begin
        pair = 2'h2;
      end
    endcase
    ack_pair = pair;
  endfunction : ack_pair

  bwpc_dev_t s_reg;
  bwpc_dev_t s_next;
  logic strobe_low;
  logic strobe_rose;
  logic [31:0] joined_in;

  // Second flop stage is the first that logic reads
  assign strobe_low = !s_reg.as_sync[1] && !s_reg.ds_sync[1] && !s_reg.cs_sync[1];
  assign strobe_rose = rose(s_reg.as_sync) || rose(s_reg.ds_sync);
  assign joined_in = bwpc_pkg::bwpc_join_lanes(s_reg.width, bus.host_data);

  always_comb begin
    s_next = s_reg;
    s_next.as_sync = sync3(s_reg.as_sync, bus.address_strobe_n);
    s_next.ds_sync = sync3(s_reg.ds_sync, bus.data_strobe_n);
    s_next.cs_sync = sync2(s_reg.cs_sync, bus.chip_select_n);
    s_next.rw_sync = sync2(s_reg.rw_sync, bus.read_not_write);
    s_next.a4_sync = sync2(s_reg.a4_sync, bus.addr_bit4);
    s_next.wr_seen = 1'b0;
    // Width is caught once after reset so a moving strap cannot split a cycle
    if (!s_reg.straps_taken) begin
      s_next.width = bwpc_pkg::bwpc_decode_straps(size_strap, addr_bit0_strap);
      s_next.straps_taken = 1'b1;
    end
    unique case (s_reg.state)
      bwpc_pkg::BWPC_IDLE: begin
        s_next.ack_lo = 1'b1;
        s_next.ack_hi = 1'b1;
        if (strobe_low && s_reg.straps_taken) begin
          s_next.wait_cnt = bwpc_pkg::BWPC_WAIT_CYCLES;
          s_next.state = bwpc_pkg::BWPC_ACK;
          s_next.ack_oe = 1'b1;
        end
      end

      bwpc_pkg::BWPC_ACK: begin
        if (strobe_rose || !strobe_low) begin
          s_next.ack_lo = 1'b1;
          s_next.ack_hi = 1'b1;
          s_next.dout_oe = 1'b0;
          s_next.state = bwpc_pkg::BWPC_NEGATE;
        end else if (s_reg.wait_cnt != 4'h0) begin
          // Both negated while counting holds the host in wait states
          s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
        end else if (s_reg.ack_lo && s_reg.ack_hi) begin
          {s_next.ack_hi, s_next.ack_lo} = ack_pair(s_reg.width, s_reg.a4_sync[1]);
          // Read data is lane-joined so every lane the host may sample is valid
          if (s_reg.rw_sync[1]) begin
            s_next.dout = bwpc_pkg::bwpc_join_lanes(s_reg.width, s_reg.store);
            s_next.dout_oe = 1'b1;
          end else begin
            s_next.store = joined_in;
            s_next.wr_seen = 1'b1;
          end
        end
      end

      bwpc_pkg::BWPC_NEGATE: begin
        // Keep driving negated a full cycle so the line rises fast
        s_next.ack_lo = 1'b1;
        s_next.ack_hi = 1'b1;
        s_next.state = bwpc_pkg::BWPC_RELEASE;
      end

      bwpc_pkg::BWPC_RELEASE: begin
        // Released before the next cycle so the pull-up holds the line
        s_next.ack_oe = 1'b0;
        if (!strobe_low) begin
          s_next.state = bwpc_pkg::BWPC_IDLE;
        end
      end
    endcase
  end

  // Clock enable low freezes every flop, synchronisers included
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= BWPC_DEV_RESET;
    end else if (clock_en) begin
      s_reg <= s_next;
    end
  end

  // One enable for both acknowledges: driven and released together
  assign bus.ack_low_order_out = s_reg.ack_lo;
  assign bus.ack_high_order_out = s_reg.ack_hi;
  assign bus.ack_low_order_oe = s_reg.ack_oe;
  assign bus.ack_high_order_oe = s_reg.ack_oe;
  assign bus.dev_data = s_reg.dout;
  assign bus.dev_data_oe = s_reg.dout_oe;

  assign bus_width = s_reg.width;
  assign last_write_data = s_reg.store;
  assign write_seen = s_reg.wr_seen;
endmodule : bwpc_device
`default_nettype wire

// ===== hdl/bwpc_host.sv
// Purpose: Host end: runs one strobed cycle per request and ends it on acknowledge.
// Assumes: Chip select decode done by the user; acknowledges come from another domain.
// Notes: Data lanes are joined on the write side as the selected width needs.
`timescale 1ns/1ps
`default_nettype none
module bwpc_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic [1:0] bus_width,
  input wire logic peripheral_8bit,
  input wire logic req,
  input wire logic req_read,
  input wire logic req_addr_bit4,
  input wire logic [31:0] req_wdata,
  bwpc_if.host bus,
  output logic done,
  output logic timeout,
  output logic [31:0] rdata,
  output logic busy
);
  typedef struct packed {
    logic [1:0] lo_sync;
    logic [1:0] hi_sync;
    bwpc_pkg::bwpc_host_state_t state;
    logic [7:0] cnt;
    logic strobe_n;
    logic rw;
    logic a4;
    logic [31:0] wdata;
    logic [31:0] rd;
    logic done;
    logic tmo;
  } bwpc_host_st_t;

  bwpc_host_st_t h_reg;
  bwpc_host_st_t h_next;
  logic acked;

  // 8-bit peripheral wiring listens to the low acknowledge only
  assign acked = peripheral_8bit ? !h_reg.lo_sync[1]
                 : (!h_reg.lo_sync[1] || !h_reg.hi_sync[1]);

  always_comb begin
    h_next = h_reg;
    h_next.lo_sync = {h_reg.lo_sync[0], bus.ack_low_order};
    h_next.hi_sync = {h_reg.hi_sync[0], bus.ack_high_order};
    h_next.done = 1'b0;
    h_next.tmo = 1'b0;
    unique case (h_reg.state)
      bwpc_pkg::BWPC_H_IDLE: begin
        if (req) begin
          h_next.strobe_n = 1'b0;
          h_next.rw = req_read;
          h_next.a4 = req_addr_bit4;
          h_next.wdata = bwpc_pkg::bwpc_join_lanes(bus_width, req_wdata);
          h_next.cnt = bwpc_pkg::BWPC_HOST_TIMEOUT;
          h_next.state = bwpc_pkg::BWPC_H_WAIT;
        end
      end
      bwpc_pkg::BWPC_H_WAIT: begin
        if (acked) begin
          h_next.rd = bwpc_pkg::bwpc_join_lanes(bus_width, bus.dev_data);
          h_next.strobe_n = 1'b1;
          h_next.done = 1'b1;
          h_next.state = bwpc_pkg::BWPC_H_END;
        end else if (h_reg.cnt == 8'h00) begin
          h_next.strobe_n = 1'b1;
          h_next.tmo = 1'b1;
          h_next.state = bwpc_pkg::BWPC_H_END;
        end else begin
          h_next.cnt = h_reg.cnt - 8'h01;
        end
      end
      default: begin
        // Wait for the acknowledges to return high before a new cycle
        if (h_reg.lo_sync[1] && h_reg.hi_sync[1]) begin
          h_next.state = bwpc_pkg::BWPC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      h_reg <= '{lo_sync: 2'h3, hi_sync: 2'h3, state: bwpc_pkg::BWPC_H_IDLE,
                 cnt: 8'h00, strobe_n: 1'b1, rw: 1'b1, a4: 1'b0,
                 wdata: bwpc_pkg::BWPC_DATA_RESET, rd: bwpc_pkg::BWPC_DATA_RESET,
                 done: 1'b0, tmo: 1'b0};
    end else if (clock_en) begin
      h_reg <= h_next;
    end
  end

  // Chip select follows the strobe; decode space is the user's concern
  assign bus.address_strobe_n = h_reg.strobe_n;
  assign bus.data_strobe_n = h_reg.strobe_n;
  assign bus.chip_select_n = h_reg.strobe_n;
  assign bus.read_not_write = h_reg.rw;
  assign bus.addr_bit4 = h_reg.a4;
  assign bus.host_data = h_reg.wdata;
  assign done = h_reg.done;
  assign timeout = h_reg.tmo;
  assign rdata = h_reg.rd;
  assign busy = (h_reg.state != bwpc_pkg::BWPC_H_IDLE);
endmodule : bwpc_host
`default_nettype wire

// ===== verification/bwpc_checker_sva.sv
// Purpose: Wire checks on the acknowledge pins between host and device.
// Assumes: One clock, reset active high.
// Notes: Takes the interface signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module bwpc_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] bus_width,
  input wire logic address_strobe_n,
  input wire logic addr_bit4,
  input wire logic ack_low_order,
  input wire logic ack_high_order,
  input wire logic ack_low_order_out,
  input wire logic ack_low_order_oe,
  input wire logic ack_high_order_out,
  input wire logic ack_high_order_oe
);
  localparam logic [1:0] W8 = bwpc_pkg::BWPC_W8;
  localparam logic [1:0] W16 = bwpc_pkg::BWPC_W16;
  localparam logic [1:0] W32 = bwpc_pkg::BWPC_W32;
  logic [1:0] age_reg;
  logic both_neg;
  assign both_neg = ack_low_order && ack_high_order;
  // Width settles one edge after release, so hold is judged from the third
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h2) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_W16_NO_LOW: assert property (bus_width == W16 |-> ack_low_order)
    else $error("low ack on 16-bit bus");
  AST_W8_NO_HIGH: assert property (bus_width == W8 |-> ack_high_order)
    else $error("high ack on 8-bit bus");
  AST_W32_A4_LOW: assert property ((bus_width == W32 && !address_strobe_n && !addr_bit4)
    |-> ack_low_order)
    else $error("low ack with bit4 zero");
  AST_W32_BOTH: assert property ((bus_width == W32 && !address_strobe_n && addr_bit4
    && !ack_high_order) |-> !ack_low_order)
    else $error("bit4 one without both acks");
  AST_WAIT: assert property ($fell(address_strobe_n) |-> both_neg [*4])
    else $error("ack too early");
  AST_RELEASE: assert property ($rose(address_strobe_n)
    |-> ##[1:8] (!ack_low_order_oe && !ack_high_order_oe))
    else $error("acks not released");
  AST_NEG_LOW: assert property ($fell(ack_low_order_oe) |-> $past(ack_low_order_out))
    else $error("low ack released while low");
  AST_NEG_HIGH: assert property ($fell(ack_high_order_oe) |-> $past(ack_high_order_out))
    else $error("high ack released while low");
  AST_WIDTH_HOLD: assert property (age_reg == 2'h2 |-> $stable(bus_width))
    else $error("width moved");
endmodule : bwpc_checker
`default_nettype wire

// ===== verification/bus_width_port_config_tb.sv
// Purpose: Runs both ends over every strap setting and checks acks and lanes.
// Assumes: 50 MHz clock, reset held two cycles.
// Notes: Read data is the stored word, lane-joined for the selected width.
`timescale 1ns/1ps
`default_nettype none
module bus_width_port_config_tb;
  localparam logic [1:0] W8 = bwpc_pkg::BWPC_W8;
  localparam logic [1:0] W32 = bwpc_pkg::BWPC_W32;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic a0_strap = 1'b1;
  logic size_strap = 1'b1;
  logic periph8 = 1'b0;
  logic req = 1'b0;
  logic req_read = 1'b0;
  logic req_a4 = 1'b0;
  logic [31:0] req_wdata = 32'h0;
  logic [1:0] width;
  logic [1:0] ew;
  logic [31:0] wr_word;
  logic [31:0] rdata;
  logic done;
  logic tmo;
  logic busy;
  logic lo_seen;
  logic hi_seen;
  int n_mismatch = 0;
  int cmp_count = 0;
  bwpc_if bus_if ();
  bwpc_device i_bwpc_device (.clock(clock), .rst(rst), .clock_en(1'b1),
    .addr_bit0_strap(a0_strap), .size_strap(size_strap), .bus(bus_if.device),
    .bus_width(width), .last_write_data(wr_word), .write_seen());
  bwpc_host i_bwpc_host (.clock(clock), .rst(rst), .clock_en(1'b1), .bus_width(width),
    .peripheral_8bit(periph8), .req(req), .req_read(req_read), .req_addr_bit4(req_a4),
    .req_wdata(req_wdata), .bus(bus_if.host), .done(done), .timeout(tmo),
    .rdata(rdata), .busy(busy));
  bwpc_checker i_bwpc_checker (.clock(clock), .rst(rst), .bus_width(width),
    .address_strobe_n(bus_if.address_strobe_n), .addr_bit4(bus_if.addr_bit4),
    .ack_low_order(bus_if.ack_low_order), .ack_high_order(bus_if.ack_high_order),
    .ack_low_order_out(bus_if.ack_low_order_out),
    .ack_low_order_oe(bus_if.ack_low_order_oe),
    .ack_high_order_out(bus_if.ack_high_order_out),
    .ack_high_order_oe(bus_if.ack_high_order_oe));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (bus_if.ack_low_order === 1'b0) lo_seen = 1'b1;
    if (bus_if.ack_high_order === 1'b0) hi_seen = 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] lanes(input logic [31:0] d);
    if (ew == W8) return {4{d[7:0]}};
    if (ew == W32) return d;
    return {2{d[15:0]}};
  endfunction : lanes
  task automatic do_reset(input logic a0, input logic sz);
    @(posedge clock);
    rst <= 1'b1;
    a0_strap <= a0;
    size_strap <= sz;
    periph8 <= !sz;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : do_reset
  // One strobed cycle; ack sightings are gathered by the monitor above
  task automatic xfer(input logic rd, input logic a4, input logic [31:0] wd);
    int n;
    @(posedge clock);
    req <= 1'b1;
    req_read <= rd;
    req_a4 <= a4;
    req_wdata <= wd;
    lo_seen = 1'b0;
    hi_seen = 1'b0;
    @(posedge clock);
    req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n >= 300), 32'h0, "no done");
    chk(tmo, 1'b0, "timeout");
    while ((busy !== 1'b0 || bus_if.ack_low_order_oe !== 1'b0
      || bus_if.ack_high_order_oe !== 1'b0) && n < 300) begin
      @(posedge clock);
      n++;
    end
    chk(lo_seen, ew == W8 || (ew == W32 && a4), "low ack");
    chk(hi_seen, ew != W8, "high ack");
    if (!rd) chk(wr_word, lanes(wd), "write lanes");
  endtask : xfer
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      ew = i[1] ? {i[0], 1'b1} : W8;
      do_reset(i[0], i[1]);
      chk(width, ew, "width");
      xfer(1'b0, 1'b0, 32'hA5C31E7F);
      xfer(1'b0, 1'b1, 32'h5A3CE187);
      xfer(1'b1, 1'b1, 32'h0);
      chk(rdata, lanes(32'h5A3CE187), "read lanes");
    end
    // Straps moved without reset must not change the port
    @(posedge clock);
    a0_strap <= 1'b0;
    size_strap <= 1'b0;
    xfer(1'b0, 1'b1, 32'h12345678);
    chk(width, W32, "width kept");
    wrap_up();
  end
endmodule : bus_width_port_config_tb
`default_nettype wire
